// >>> rtl/sacl_pkg.sv
/*
  sacl_pkg: offsets, field positions, reset values and fixed codes for the
  per-port access-control / latency-reporting register slice.
  assumes: byte addressing on a 32-bit AXI4-Lite bus, one register per word.
*/
package sacl_pkg;
  // register byte offsets
  localparam logic [11:0] SACL_OFF_PWR_BUDGET_CAP = 12'h218;
  localparam logic [11:0] SACL_OFF_ACS_HDR        = 12'h220;
  localparam logic [11:0] SACL_OFF_ACS_CAP_CTRL   = 12'h224;
  localparam logic [11:0] SACL_OFF_EGRESS_VEC     = 12'h228;
  localparam logic [11:0] SACL_OFF_LTR_HDR        = 12'h230;
  localparam logic [11:0] SACL_OFF_MAX_SNOOP      = 12'h234;
  localparam logic [11:0] SACL_OFF_PORT_CFG       = 12'h300;

  // extended capability header fields
  localparam logic [15:0] SACL_ACS_CAP_ID   = 16'h000D;
  localparam logic [15:0] SACL_LTR_CAP_ID   = 16'h0018;
  localparam logic [3:0]  SACL_CAP_VERSION  = 4'h1;
  localparam logic [11:0] SACL_NEXT_PTR_RST = 12'h240;

  // access-control capability / control fields
  localparam int          SACL_CAP_LSB      = 0;
  localparam int          SACL_CAP_BITS     = 7;
  localparam logic [6:0]  SACL_CAP_RST      = 7'h7F;
  localparam int          SACL_VSIZE_LSB    = 8;
  localparam logic [7:0]  SACL_VSIZE_RST    = 8'h08;
  localparam int          SACL_EN_LSB       = 16;
  localparam logic [6:0]  SACL_EN_RST       = 7'h00;
  localparam logic [7:0]  SACL_EGRESS_RST   = 8'h00;

  // max snoop latency fields
  localparam int          SACL_LAT_VAL_LSB  = 0;
  localparam logic [9:0]  SACL_LAT_VAL_RST  = 10'h000;
  localparam int          SACL_LAT_SCL_LSB  = 10;
  localparam logic [2:0]  SACL_LAT_SCL_RST  = 3'h0;

  // power budget capability
  localparam logic        SACL_SYS_ALLOC_RST = 1'h0;

  // axi response codes
  localparam logic [1:0]  SACL_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  SACL_RESP_SLVERR  = 2'h2;
endpackage : sacl_pkg

// >>> rtl/sacl_strap_load.sv
/*
  sacl_strap_load: holds the overridable read-only default of the power
  budget system-allocated flag.
  assumes: the serial management / eeprom loader drives a one-cycle load
  strobe with data on the same clock.
*/
`timescale 1ns/1ps
module sacl_strap_load (
  input  wire logic aclk,       // core clock
  input  wire logic aresetn,    // sync reset, active low
  input  wire logic load_valid, // loader strobe
  input  wire logic load_value, // loader data
  output logic      value       // held default
);
  import sacl_pkg::*;

  // reset to documented default, only the loader may change it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      value <= SACL_SYS_ALLOC_RST;
    end else if (load_valid) begin
      value <= load_value;
    end
  end
endmodule : sacl_strap_load

// >>> rtl/sacl_port_role.sv
/*
  sacl_port_role: follows the port-role strap every cycle after reset release.
  assumes: strap_upstream is a pin, asynchronous to aclk, static in use.
*/
`timescale 1ns/1ps
module sacl_port_role (
  input  wire logic aclk,           // core clock
  input  wire logic aresetn,        // sync reset, active low
  input  wire logic strap_upstream, // raw strap pin
  output logic      is_upstream     // synchronised role
);
  logic sync1_reg;
  logic sync2_reg;

  // two-stage synchroniser then role register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg   <= 1'b0;
      sync2_reg   <= 1'b0;
      is_upstream <= 1'b0;
    end else begin
      sync1_reg   <= strap_upstream;
      sync2_reg   <= sync1_reg;
      is_upstream <= sync2_reg;
    end
  end
endmodule : sacl_port_role

// >>> rtl/sacl_regs.sv
/*
  sacl_regs: per-port register slice with power budget flag, access-control
  capability (downstream role) and latency-reporting capability (upstream
  role), reached over AXI4-Lite.
  assumes: single clock aclk, synchronous active-low aresetn; the loader
  strobe and enable outputs sit on aclk; the role strap is a pin.

  // How it works
  // [R01] system-allocated bit read-only, reset zero, loadable
  // [R02] access-control header returns fixed id
  // [R03] both headers version 1, next pointer 240h
  // [R04] seven capability bits read-only, reset one
  // [R05] egress vector size reads 8
  // [R06] seven enable bits read-write, reset zero
  // [R07] egress vector read-write, reset zero, drives blocking
  // [R08] access-control registers only on downstream ports
  // [R09] latency header returns fixed id
  // [R10] latency registers only on upstream port
  // [R11] snoop latency value bits 9:0, read-write
  // [R12] snoop latency scale bits 12:10, read-write
  // [R13] reserved bits read zero, ignore writes
  // [R14] writes to read-only fields do nothing
*/
`timescale 1ns/1ps
module sacl_regs (
  input  wire logic        aclk,          // core clock, 20 MHz
  input  wire logic        aresetn,       // sync reset, active low
  input  wire logic [11:0] s_axi_awaddr,  // write address
  input  wire logic        s_axi_awvalid, // write address valid
  output logic             s_axi_awready, // write address ready
  input  wire logic [31:0] s_axi_wdata,   // write data
  input  wire logic [3:0]  s_axi_wstrb,   // write byte enables
  input  wire logic        s_axi_wvalid,  // write data valid
  output logic             s_axi_wready,  // write data ready
  output logic [1:0]       s_axi_bresp,   // write response
  output logic             s_axi_bvalid,  // write response valid
  input  wire logic        s_axi_bready,  // write response ready
  input  wire logic [11:0] s_axi_araddr,  // read address
  input  wire logic        s_axi_arvalid, // read address valid
  output logic             s_axi_arready, // read address ready
  output logic [31:0]      s_axi_rdata,   // read data
  output logic [1:0]       s_axi_rresp,   // read response
  output logic             s_axi_rvalid,  // read data valid
  input  wire logic        s_axi_rready,  // read data ready
  input  wire logic        strap_upstream,// port role strap pin
  input  wire logic        dflt_load,     // default loader strobe
  input  wire logic        dflt_sys_alloc,// loader value for flag
  output logic             is_upstream,   // current port role
  output logic [6:0]       acs_enable,    // feature enables to datapath
  output logic [7:0]       egress_block,  // per-target-port block mask
  output logic [9:0]       snoop_lat_val, // max snoop latency value
  output logic [2:0]       snoop_lat_scl  // max snoop latency scale
);
  import sacl_pkg::*;

  logic        sys_alloc;
  logic [6:0]  acs_en_reg;
  logic [7:0]  egress_reg;
  logic [9:0]  lat_val_reg;
  logic [2:0]  lat_scl_reg;
  logic        aw_held_reg;
  logic [11:0] aw_addr_reg;
  logic        w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        do_write;
  logic [31:0] rd_word;
  logic        rd_hit;
  logic [31:0] acs_merged;
  logic [31:0] egress_merged;
  logic [31:0] lat_merged;

  // loadable default of the system-allocated flag
  sacl_strap_load u_strap_load (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .load_valid (dflt_load),
    .load_value (dflt_sys_alloc),
    .value      (sys_alloc)
  );

  // port role from strap pin
  sacl_port_role u_port_role (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .strap_upstream (strap_upstream),
    .is_upstream    (is_upstream)
  );

  // merges byte lanes of a write into an old word
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0]  strb);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  // builds an extended capability header word
  function automatic logic [31:0] ext_header(input logic [15:0] cap_id);
    return {SACL_NEXT_PTR_RST, SACL_CAP_VERSION, cap_id}; // [R03]
  endfunction : ext_header

  // tells whether an offset exists for the current role
  function automatic logic offset_mapped(input logic [11:0] addr,
                                         input logic        upstream);
    logic hit;
    hit = 1'b0;
    case (addr)
      SACL_OFF_PWR_BUDGET_CAP: hit = 1'b1;
      SACL_OFF_ACS_HDR,
      SACL_OFF_ACS_CAP_CTRL,
      SACL_OFF_EGRESS_VEC:     hit = !upstream; // [R08]
      SACL_OFF_LTR_HDR,
      SACL_OFF_MAX_SNOOP:      hit = upstream;  // [R10]
      default:                 hit = 1'b0;
    endcase
    return hit;
  endfunction : offset_mapped

  // write address / data capture, taken in either order
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign do_write      = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= {s_axi_awaddr[11:2], 2'b00};
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  // write response, error for unmapped offsets
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= SACL_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= offset_mapped(aw_addr_reg, is_upstream) ?
                      SACL_RESP_OKAY : SACL_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // stored fields with the written byte lanes merged in
  assign acs_merged    = merge_bytes({9'h000, acs_en_reg, 16'h0000}, w_data_reg, w_strb_reg);
  assign egress_merged = merge_bytes({24'h000000, egress_reg}, w_data_reg, w_strb_reg);
  assign lat_merged    = merge_bytes({19'h00000, lat_scl_reg, lat_val_reg}, w_data_reg,
                                     w_strb_reg);

  // access-control enables, only writable bits stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acs_en_reg <= SACL_EN_RST; // [R06]
    end else if (do_write && !is_upstream && aw_addr_reg == SACL_OFF_ACS_CAP_CTRL) begin
      acs_en_reg <= acs_merged[SACL_EN_LSB +: SACL_CAP_BITS]; // [R06] [R14]
    end
  end

  // egress block vector
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      egress_reg <= SACL_EGRESS_RST; // [R07]
    end else if (do_write && !is_upstream && aw_addr_reg == SACL_OFF_EGRESS_VEC) begin
      egress_reg <= egress_merged[7:0]; // [R07] [R13]
    end
  end

  // max snoop latency value and scale
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lat_val_reg <= SACL_LAT_VAL_RST; // [R11]
      lat_scl_reg <= SACL_LAT_SCL_RST; // [R12]
    end else if (do_write && is_upstream && aw_addr_reg == SACL_OFF_MAX_SNOOP) begin
      lat_val_reg <= lat_merged[SACL_LAT_VAL_LSB +: 10]; // [R11]
      lat_scl_reg <= lat_merged[SACL_LAT_SCL_LSB +: 3]; // [R12]
    end
  end

  // read word assembly, reserved bits zero
  always_comb begin
    rd_word = 32'h00000000;
    rd_hit  = offset_mapped({s_axi_araddr[11:2], 2'b00}, is_upstream);
    if (rd_hit) begin
      case ({s_axi_araddr[11:2], 2'b00})
        SACL_OFF_PWR_BUDGET_CAP: rd_word = {31'h00000000, sys_alloc}; // [R01] [R13]
        SACL_OFF_ACS_HDR:        rd_word = ext_header(SACL_ACS_CAP_ID); // [R02]
        SACL_OFF_ACS_CAP_CTRL:   rd_word = {9'h000, acs_en_reg, SACL_VSIZE_RST,
                                            1'b0, SACL_CAP_RST}; // [R04] [R05] [R13]
        SACL_OFF_EGRESS_VEC:     rd_word = {24'h000000, egress_reg}; // [R07]
        SACL_OFF_LTR_HDR:        rd_word = ext_header(SACL_LTR_CAP_ID); // [R09]
        SACL_OFF_MAX_SNOOP:      rd_word = {19'h00000, lat_scl_reg, lat_val_reg}; // [R11] [R12]
        default:                 rd_word = 32'h00000000;
      endcase
    end
  end

  // read channel, one outstanding read
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= SACL_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? SACL_RESP_OKAY : SACL_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // outputs to datapath, access-control ones gated by role, latency ones not
  assign acs_enable    = is_upstream ? 7'h00 : acs_en_reg; // [R08]
  assign egress_block  = is_upstream ? 8'h00 : egress_reg; // [R07] [R08]
  assign snoop_lat_val = lat_val_reg;
  assign snoop_lat_scl = lat_scl_reg;

  // a write to the enables lands one cycle after the join
  acs_en_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R06]
    do_write && !is_upstream && aw_addr_reg == SACL_OFF_ACS_CAP_CTRL && w_strb_reg[2]
    |=> acs_en_reg == $past(w_data_reg[22:16]))
    else $error("enable bits not updated");

  // capability and size fields never move
  cap_const_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R04]
    s_axi_arvalid && s_axi_arready && !is_upstream &&
    {s_axi_araddr[11:2], 2'b00} == SACL_OFF_ACS_CAP_CTRL
    |=> s_axi_rdata[15:0] == 16'h087F && s_axi_rdata[31:23] == 9'h000)
    else $error("capability word wrong");

  // headers carry id, version and pointer
  acs_hdr_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R02]
    s_axi_arvalid && s_axi_arready && !is_upstream &&
    {s_axi_araddr[11:2], 2'b00} == SACL_OFF_ACS_HDR
    |=> s_axi_rdata == 32'h2401000D)
    else $error("acs header wrong");

  ltr_hdr_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R09]
    s_axi_arvalid && s_axi_arready && is_upstream &&
    {s_axi_araddr[11:2], 2'b00} == SACL_OFF_LTR_HDR
    |=> s_axi_rdata == 32'h24010018)
    else $error("ltr header wrong");

  // role gating of the two capabilities
  role_gate_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R08]
    s_axi_arvalid && s_axi_arready && is_upstream &&
    {s_axi_araddr[11:2], 2'b00} == SACL_OFF_EGRESS_VEC
    |=> s_axi_rresp == SACL_RESP_SLVERR && s_axi_rdata == 32'h00000000)
    else $error("downstream register seen upstream");

  ltr_gate_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
    do_write && !is_upstream |=> $stable(lat_val_reg) && $stable(lat_scl_reg))
    else $error("latency changed on downstream port");

  // flag changes only by the loader
  sys_alloc_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R01] [R14]
    !dflt_load |=> $stable(sys_alloc))
    else $error("flag changed without loader");

  // snoop latency reserved bits read zero
  snoop_rsvd_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R11] [R12] [R13]
    s_axi_arvalid && s_axi_arready && is_upstream &&
    {s_axi_araddr[11:2], 2'b00} == SACL_OFF_MAX_SNOOP
    |=> s_axi_rdata[31:13] == 19'h00000 && s_axi_rdata[9:0] == $past(lat_val_reg))
    else $error("snoop latency read wrong");

  // every writable field leaves reset at its default
  reset_vals_a: assert property (@(posedge aclk) // [R01] [R06] [R07] [R11] [R12]
    !aresetn |=> sys_alloc == SACL_SYS_ALLOC_RST && acs_en_reg == SACL_EN_RST &&
    egress_reg == SACL_EGRESS_RST && lat_val_reg == SACL_LAT_VAL_RST &&
    lat_scl_reg == SACL_LAT_SCL_RST)
    else $error("register not at reset value");

  // writable fields take exactly the written lanes
  egress_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R07]
    do_write && !is_upstream && aw_addr_reg == SACL_OFF_EGRESS_VEC && w_strb_reg[0]
    |=> egress_reg == $past(w_data_reg[7:0]))
    else $error("egress vector not updated");

  lat_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R11] [R12]
    do_write && is_upstream && aw_addr_reg == SACL_OFF_MAX_SNOOP && w_strb_reg[1:0] == 2'h3
    |=> lat_val_reg == $past(w_data_reg[9:0]) && lat_scl_reg == $past(w_data_reg[12:10]))
    else $error("snoop latency not updated");

  // read data of the flag and the egress vector
  pwr_read_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R01] [R13]
    s_axi_arvalid && s_axi_arready && {s_axi_araddr[11:2], 2'b00} == SACL_OFF_PWR_BUDGET_CAP
    |=> s_axi_rresp == SACL_RESP_OKAY && s_axi_rdata == {31'h00000000, $past(sys_alloc)})
    else $error("power budget flag read wrong");

  egress_rsvd_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R07] [R13]
    s_axi_arvalid && s_axi_arready && !is_upstream &&
    {s_axi_araddr[11:2], 2'b00} == SACL_OFF_EGRESS_VEC
    |=> s_axi_rdata == {24'h000000, $past(egress_reg)})
    else $error("egress vector read wrong");

  // role gating in the other direction
  ltr_hidden_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
    s_axi_arvalid && s_axi_arready && !is_upstream &&
    {s_axi_araddr[11:2], 2'b00} == SACL_OFF_MAX_SNOOP
    |=> s_axi_rresp == SACL_RESP_SLVERR && s_axi_rdata == 32'h00000000)
    else $error("upstream register seen downstream");

  acs_hidden_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R08]
    do_write && is_upstream |=> $stable(acs_en_reg) && $stable(egress_reg))
    else $error("access-control state written upstream");

  // a write elsewhere leaves the enables alone
  ro_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && aw_addr_reg != SACL_OFF_ACS_CAP_CTRL |=> $stable(acs_en_reg))
    else $error("enable bits moved by another write");

  // bus answers one cycle after the request is joined
  rd_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");

  wr_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("write not answered next cycle");
endmodule : sacl_regs

// >>> verif/switch_port_acs_ltr_capability_regs_bench.sv
/*
  bench for sacl_regs: drives the axi4-lite slave, role strap and default
  loader, and checks register contents, responses and role-gated outputs.
  assumes: sacl_pkg compiled first; one 20 MHz clock, sync active-low reset.
*/
`timescale 1ns/1ps
module switch_port_acs_ltr_capability_regs_bench;
  import sacl_pkg::*;
  logic        aclk;
  logic        aresetn;
  logic [11:0] s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [11:0] s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic        strap_upstream;
  logic        dflt_load;
  logic        dflt_sys_alloc;
  logic        is_upstream;
  logic [6:0]  acs_enable;
  logic [7:0]  egress_block;
  logic [9:0]  snoop_lat_val;
  logic [2:0]  snoop_lat_scl;
  int          bad_count;
  int          total_checks;

  sacl_regs u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .strap_upstream(strap_upstream),
    .dflt_load(dflt_load), .dflt_sys_alloc(dflt_sys_alloc),
    .is_upstream(is_upstream), .acs_enable(acs_enable),
    .egress_block(egress_block), .snoop_lat_val(snoop_lat_val),
    .snoop_lat_scl(snoop_lat_scl)
  );

  // clock, 50 ns period
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word

  task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_resp

  // write one word; each channel released at its own handshake edge
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    int n;
    @(posedge aclk);
    n = 0;
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    forever begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        chk_resp($sformatf("bresp %h", a), er, s_axi_bresp);
        s_axi_bready <= 1'b0;
        break;
      end
      if (n > 100) begin
        bad_count++;
        close_out();
      end
    end
  endtask : axi_wr

  // read one word and judge data and response at the rvalid edge
  task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge aclk);
    n = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    forever begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        chk_word($sformatf("rdata %h", a), ed, s_axi_rdata);
        chk_resp($sformatf("rresp %h", a), er, s_axi_rresp);
        s_axi_rready <= 1'b0;
        break;
      end
      if (n > 100) begin
        bad_count++;
        close_out();
      end
    end
  endtask : axi_rd

  // downstream role straight after reset
  task automatic t_reset_state;
    axi_rd(12'h218, 32'h00000000, SACL_RESP_OKAY);
    axi_rd(12'h220, 32'h2401000D, SACL_RESP_OKAY);
    axi_rd(12'h224, 32'h0000087F, SACL_RESP_OKAY);
    axi_rd(12'h228, 32'h00000000, SACL_RESP_OKAY);
    axi_rd(12'h230, 32'h00000000, SACL_RESP_SLVERR);
    axi_rd(12'h234, 32'h00000000, SACL_RESP_SLVERR);
    chk_word("is_upstream", 32'h0, {31'h0, is_upstream});
  endtask : t_reset_state

  // enables, byte lanes, egress vector and read-only fields
  task automatic t_acs_fields;
    axi_wr(12'h224, 32'hFFFFFFFF, 4'hF, SACL_RESP_OKAY);
    axi_rd(12'h224, 32'h007F087F, SACL_RESP_OKAY);
    chk_word("acs_enable", 32'h7F, {25'h0, acs_enable});
    axi_wr(12'h224, 32'h00000000, 4'hB, SACL_RESP_OKAY);
    axi_rd(12'h224, 32'h007F087F, SACL_RESP_OKAY);
    axi_wr(12'h224, 32'h00150000, 4'h4, SACL_RESP_OKAY);
    axi_rd(12'h224, 32'h0015087F, SACL_RESP_OKAY);
    chk_word("acs_enable", 32'h15, {25'h0, acs_enable});
    axi_wr(12'h228, 32'hFFFFFFFF, 4'hF, SACL_RESP_OKAY);
    axi_rd(12'h228, 32'h000000FF, SACL_RESP_OKAY);
    axi_wr(12'h228, 32'hFFFFFF5A, 4'h1, SACL_RESP_OKAY);
    axi_rd(12'h228, 32'h0000005A, SACL_RESP_OKAY);
    chk_word("egress_block", 32'h5A, {24'h0, egress_block});
    axi_wr(12'h220, 32'h00000000, 4'hF, SACL_RESP_OKAY);
    axi_rd(12'h220, 32'h2401000D, SACL_RESP_OKAY);
    axi_wr(12'h218, 32'hFFFFFFFF, 4'hF, SACL_RESP_OKAY);
    axi_rd(12'h218, 32'h00000000, SACL_RESP_OKAY);
  endtask : t_acs_fields

  // default loader sets and clears the system-allocated flag
  task automatic t_loader;
    @(posedge aclk);
    dflt_load      <= 1'b1;
    dflt_sys_alloc <= 1'b1;
    @(posedge aclk);
    dflt_load      <= 1'b0;
    axi_rd(12'h218, 32'h00000001, SACL_RESP_OKAY);
    axi_wr(12'h218, 32'h00000000, 4'hF, SACL_RESP_OKAY);
    axi_rd(12'h218, 32'h00000001, SACL_RESP_OKAY);
    dflt_load      <= 1'b1;
    dflt_sys_alloc <= 1'b0;
    @(posedge aclk);
    dflt_load      <= 1'b0;
    axi_rd(12'h218, 32'h00000000, SACL_RESP_OKAY);
  endtask : t_loader

  // upstream role: latency registers live, access-control ones gone
  task automatic t_upstream;
    strap_upstream <= 1'b1;
    repeat (5) @(posedge aclk);
    chk_word("is_upstream", 32'h1, {31'h0, is_upstream});
    chk_word("acs_enable", 32'h0, {25'h0, acs_enable});
    chk_word("egress_block", 32'h0, {24'h0, egress_block});
    axi_rd(12'h220, 32'h00000000, SACL_RESP_SLVERR);
    axi_rd(12'h228, 32'h00000000, SACL_RESP_SLVERR);
    axi_wr(12'h224, 32'hFFFFFFFF, 4'hF, SACL_RESP_SLVERR);
    axi_rd(12'h230, 32'h24010018, SACL_RESP_OKAY);
    axi_rd(12'h234, 32'h00000000, SACL_RESP_OKAY);
    axi_wr(12'h234, 32'hFFFFFFFF, 4'hF, SACL_RESP_OKAY);
    axi_rd(12'h234, 32'h00001FFF, SACL_RESP_OKAY);
    axi_wr(12'h234, 32'h00001555, 4'h3, SACL_RESP_OKAY);
    axi_rd(12'h234, 32'h00001555, SACL_RESP_OKAY);
    chk_word("snoop_lat_val", 32'h155, {22'h0, snoop_lat_val});
    chk_word("snoop_lat_scl", 32'h5, {29'h0, snoop_lat_scl});
    axi_rd(12'h300, 32'h00000000, SACL_RESP_SLVERR);
    axi_wr(12'h23C, 32'hFFFFFFFF, 4'hF, SACL_RESP_SLVERR);
  endtask : t_upstream

  // watchdog, far beyond the roughly 150 cycles the tests need
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    close_out();
  end

  // main sequence
  initial begin
    bad_count      = 0;
    total_checks   = 0;
    aresetn        = 1'b0;
    s_axi_awaddr   = 12'h000;
    s_axi_awvalid  = 1'b0;
    s_axi_wdata    = 32'h00000000;
    s_axi_wstrb    = 4'h0;
    s_axi_wvalid   = 1'b0;
    s_axi_bready   = 1'b0;
    s_axi_araddr   = 12'h000;
    s_axi_arvalid  = 1'b0;
    s_axi_rready   = 1'b0;
    strap_upstream = 1'b0;
    dflt_load      = 1'b0;
    dflt_sys_alloc = 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    t_reset_state();
    t_acs_fields();
    t_loader();
    t_upstream();
    close_out();
  end
endmodule : switch_port_acs_ltr_capability_regs_bench
